// *** hdl/tsc_cfg.svh ***
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH

// word indices; byte address is four times the index
`define TSC_IDX_RESTART 6'h00
`define TSC_IDX_PLL_APPLY 6'h02
`define TSC_IDX_LATENCY 6'h04
`define TSC_IDX_AMBIENT 6'h05
`define TSC_IDX_STANDBY 6'h08
`define TSC_IDX_INIT 6'h0b
`define TSC_IDX_PLL_MULT 6'h0c
`define TSC_IDX_STATUS 6'h10

// field masks, writable except status which is read-only; everything else reads zero
`define TSC_MASK_PLL_APPLY 24'h000004
`define TSC_MASK_LATENCY 24'h400000
`define TSC_MASK_AMBIENT 24'h200000
`define TSC_MASK_STANDBY 24'h000004
`define TSC_MASK_INIT 24'h002000
`define TSC_MASK_PLL_MULT 24'h3fffff
`define TSC_MASK_RESTART 24'h000001
`define TSC_MASK_STATUS 24'h000007

// field positions
`define TSC_BIT_PLL_APPLY 2
`define TSC_BIT_EARLY 22
`define TSC_BIT_AMBIENT 21
`define TSC_BIT_STANDBY 2
`define TSC_BIT_INIT 13
`define TSC_BIT_RESTART 0
`define TSC_MULT_M_HI 21
`define TSC_MULT_M_LO 16
`define TSC_MULT_FRAC_HI 15

// reset values
`define TSC_RST_ZERO 24'h000000
`define TSC_RST_STANDBY 24'h000004
`define TSC_RST_PLL_MULT 24'h100000

`endif

// *** hdl/tsc_ctrl_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface tsc_ctrl_if;
  logic pll_bit;
  logic early_en;
  logic amb_en;
  logic standby;
  logic restart;
  logic pll_apply;
  logic depth_start;
  logic pix_rst;
  logic busy;

  modport regs
  (
    output pll_bit, early_en, amb_en, standby, restart,
    input pll_apply, depth_start, pix_rst, busy
  );

  modport seq
  (
    input pll_bit, early_en, amb_en, standby, restart,
    output pll_apply, depth_start, pix_rst, busy
  );
endinterface
`default_nettype wire

// *** hdl/tsc_ctrl_regs.sv ***
// Overview of operation
// RQ1 - software writes apply bit high then low; pll changes only then
// RQ2 - early enable starts depth processing right after the last quad readout
// RQ3 - strong-light enable keeps pixel reset asserted during the whole readout; here pixel reset follows readout one cycle late
// RQ4 - software sets strong-light enable only while the shutter is enabled
// RQ5 - standby bit at one holds standby; clearing it leaves standby
// RQ6 - standby bit resets to one, standby register reads four
// RQ7 - software writes the setup bit to one during initialization
// RQ8 - unused bits read zero; software writes zero into them
// RQ9 - registers are 24 bits and keep written values until overwritten
// RQ10 - soft restart bit reinitialises sensor and returns registers to defaults
`timescale 1ns/1ps
`default_nettype none
`include "tsc_cfg.svh"
module tsc_ctrl_regs
  import tsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic quad_done_i,
  input wire logic frame_end_i,
  input wire logic readout_i,
  output logic standby_o,
  output logic init_done_o,
  output logic [5:0] mod_m_o,
  output logic [15:0] mod_frac_o,
  output logic pll_apply_o,
  output logic depth_start_o,
  output logic pix_rst_o,
  output logic restart_o
);

  tsc_regs_t r;
  tsc_regs_t next_r;
  tsc_ctrl_if ctl();

  logic req;
  logic wr;
  logic [5:0] idx;
  logic [2:0] lanes;
  tsc_word_t wdat;
  logic soft_hit;

  // merge write data into a register through lanes and field mask
  function automatic tsc_word_t wmerge(input tsc_word_t old,
                                        input tsc_word_t wd,
                                        input logic [2:0] sel,
                                        input tsc_word_t fmask);
    tsc_word_t m;
    m = {{8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & fmask;
    return (old & ~m) | (wd & m);
  endfunction

  // new request seen once; ack is not yet up
  assign req = wb_cyc_i && wb_stb_i && !r.ack;
  assign wr = req && wb_we_i;
  assign idx = wb_adr_i[7:2];
  assign lanes = wb_sel_i[2:0];
  assign wdat = wb_dat_i[23:0];
  assign soft_hit = wr && (idx == `TSC_IDX_RESTART) && lanes[0]
                    && wdat[`TSC_BIT_RESTART];

  // register file next state
  always_comb
  begin
    next_r = r;
    next_r.ack = req;
    next_r.restart = 1'b0;
    // only writable fields are stored, so spare bits stay zero [RQ8]
    if (wr)
    begin
      if (idx == `TSC_IDX_PLL_APPLY)
      begin
        next_r.pll_reg = wmerge(r.pll_reg, wdat, lanes,
                                `TSC_MASK_PLL_APPLY); // [RQ9]
      end
      else if (idx == `TSC_IDX_LATENCY)
      begin
        next_r.lat_reg = wmerge(r.lat_reg, wdat, lanes,
                                `TSC_MASK_LATENCY); // [RQ9]
      end
      else if (idx == `TSC_IDX_AMBIENT)
      begin
        next_r.amb_reg = wmerge(r.amb_reg, wdat, lanes,
                                `TSC_MASK_AMBIENT); // [RQ9]
      end
      else if (idx == `TSC_IDX_STANDBY)
      begin
        next_r.stby_reg = wmerge(r.stby_reg, wdat, lanes,
                                 `TSC_MASK_STANDBY); // [RQ5]
      end
      else if (idx == `TSC_IDX_INIT)
      begin
        next_r.init_reg = wmerge(r.init_reg, wdat, lanes,
                                 `TSC_MASK_INIT); // [RQ9]
      end
      else if (idx == `TSC_IDX_PLL_MULT)
      begin
        next_r.mult_reg = wmerge(r.mult_reg, wdat, lanes,
                                 `TSC_MASK_PLL_MULT); // [RQ9]
      end
    end
    // read mux; unmapped and write-only spares answer zero [RQ8]
    next_r.rdata = `TSC_RST_ZERO;
    if (req && !wb_we_i)
    begin
      if (idx == `TSC_IDX_PLL_APPLY)
      begin
        next_r.rdata = r.pll_reg;
      end
      else if (idx == `TSC_IDX_LATENCY)
      begin
        next_r.rdata = r.lat_reg;
      end
      else if (idx == `TSC_IDX_AMBIENT)
      begin
        next_r.rdata = r.amb_reg;
      end
      else if (idx == `TSC_IDX_STANDBY)
      begin
        next_r.rdata = r.stby_reg; // [RQ6]
      end
      else if (idx == `TSC_IDX_INIT)
      begin
        next_r.rdata = r.init_reg;
      end
      else if (idx == `TSC_IDX_PLL_MULT)
      begin
        next_r.rdata = r.mult_reg;
      end
      else if (idx == `TSC_IDX_STATUS)
      begin
        next_r.rdata = {21'h000000, r.init_reg[`TSC_BIT_INIT],
                        ctl.busy, r.stby_reg[`TSC_BIT_STANDBY]};
      end
    end
    // soft restart: defaults everywhere, restart bit never sticks [RQ10]
    if (soft_hit)
    begin
      next_r.pll_reg = `TSC_RST_ZERO;
      next_r.lat_reg = `TSC_RST_ZERO;
      next_r.amb_reg = `TSC_RST_ZERO;
      next_r.stby_reg = `TSC_RST_STANDBY;
      next_r.init_reg = `TSC_RST_ZERO;
      next_r.mult_reg = `TSC_RST_PLL_MULT;
      next_r.restart = 1'b1;
    end
  end

  // state register; standby comes up set [RQ6]
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.stby_reg <= `TSC_RST_STANDBY; // [RQ6]
      r.mult_reg <= `TSC_RST_PLL_MULT;
    end
    else
    begin
      r <= next_r;
    end
  end

  // controls toward the sequencer
  assign ctl.pll_bit = r.pll_reg[`TSC_BIT_PLL_APPLY]; // [RQ1]
  assign ctl.early_en = r.lat_reg[`TSC_BIT_EARLY];
  assign ctl.amb_en = r.amb_reg[`TSC_BIT_AMBIENT];
  assign ctl.standby = r.stby_reg[`TSC_BIT_STANDBY]; // [RQ5]
  assign ctl.restart = r.restart;

  tsc_seq u_seq
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .quad_done_i(quad_done_i),
    .frame_end_i(frame_end_i),
    .readout_i(readout_i),
    .ctl(ctl)
  );

  // outputs, all from flops; upper bus byte reads zero
  assign wb_dat_o = {8'h00, r.rdata};
  assign wb_ack_o = r.ack;
  assign standby_o = ctl.standby;
  // setup bit only reported; software must set it
  assign init_done_o = r.init_reg[`TSC_BIT_INIT];
  assign mod_m_o = r.mult_reg[`TSC_MULT_M_HI:`TSC_MULT_M_LO];
  assign mod_frac_o = r.mult_reg[`TSC_MULT_FRAC_HI:0];
  assign pll_apply_o = ctl.pll_apply;
  assign depth_start_o = ctl.depth_start;
  assign pix_rst_o = ctl.pix_rst;
  assign restart_o = r.restart;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // helpers for the checks below
  logic past_rd;
  logic [5:0] past_idx;
  always_ff @(posedge clk_i)
  begin
    past_rd <= req && !wb_we_i;
    past_idx <= idx;
  end

  // bits that may read nonzero in the word now being answered
  tsc_word_t rd_mask;
  always_comb
  begin
    rd_mask = `TSC_RST_ZERO;
    if (past_idx == `TSC_IDX_PLL_APPLY)
    begin
      rd_mask = `TSC_MASK_PLL_APPLY;
    end
    else if (past_idx == `TSC_IDX_LATENCY)
    begin
      rd_mask = `TSC_MASK_LATENCY;
    end
    else if (past_idx == `TSC_IDX_AMBIENT)
    begin
      rd_mask = `TSC_MASK_AMBIENT;
    end
    else if (past_idx == `TSC_IDX_STANDBY)
    begin
      rd_mask = `TSC_MASK_STANDBY;
    end
    else if (past_idx == `TSC_IDX_INIT)
    begin
      rd_mask = `TSC_MASK_INIT;
    end
    else if (past_idx == `TSC_IDX_PLL_MULT)
    begin
      rd_mask = `TSC_MASK_PLL_MULT;
    end
    else if (past_idx == `TSC_IDX_STATUS)
    begin
      rd_mask = `TSC_MASK_STATUS;
    end
  end

  // every read of every word, unmapped ones included, keeps spares zero
  spare_all_a: assert property ( // [RQ8]
    wb_ack_o && past_rd
    |-> (wb_dat_o[23:0] & ~rd_mask) == 24'h000000)
    else $error("spare bits read nonzero in some word");
  read_idle_a: assert property ( // [RQ8]
    !wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside ack");

  // a write must land in the field it names, at the taking edge
  latency_write_a: assert property ( // [RQ9]
    wr && idx == `TSC_IDX_LATENCY && lanes[2]
    |=> ctl.early_en == $past(wdat[`TSC_BIT_EARLY]))
    else $error("early enable write lost");
  ambient_write_a: assert property ( // [RQ9]
    wr && idx == `TSC_IDX_AMBIENT && lanes[2]
    |=> ctl.amb_en == $past(wdat[`TSC_BIT_AMBIENT]))
    else $error("ambient enable write lost");
  standby_write_a: assert property ( // [RQ5]
    wr && idx == `TSC_IDX_STANDBY && lanes[0]
    |=> standby_o == $past(wdat[`TSC_BIT_STANDBY]))
    else $error("standby write lost");
  init_write_a: assert property ( // [RQ9]
    wr && idx == `TSC_IDX_INIT && lanes[1]
    |=> init_done_o == $past(wdat[`TSC_BIT_INIT]))
    else $error("setup bit write lost");

  standby_reset_a: assert property ( // [RQ6]
    disable iff (1'b0) rst_i |=> standby_o && r.stby_reg == 24'h000004)
    else $error("standby not set after reset");
  standby_hold_a: assert property ( // [RQ5]
    standby_o && !(wr && idx == `TSC_IDX_STANDBY) |=> standby_o)
    else $error("standby left without a write");
  soft_restart_a: assert property ( // [RQ10]
    soft_hit |=> restart_o && standby_o && !init_done_o
    && mod_m_o == 6'h10 && mod_frac_o == 16'h0000 ##1 !restart_o)
    else $error("soft restart did not restore defaults");
  spare_zero_a: assert property ( // [RQ8]
    wb_ack_o && past_rd && past_idx == `TSC_IDX_LATENCY
    |-> (wb_dat_o & ~32'h00400000) == 32'h00000000)
    else $error("spare bits read nonzero");
  top_byte_a: assert property ( // [RQ8]
    wb_ack_o |-> wb_dat_o[31:24] == 8'h00)
    else $error("upper byte nonzero");
  retain_mult_a: assert property ( // [RQ9]
    !(wr && idx == `TSC_IDX_PLL_MULT) && !soft_hit
    |=> $stable(mod_m_o) && $stable(mod_frac_o))
    else $error("multiplier changed without write");
  ack_single_a: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

  soft_restart_c: cover property (soft_hit ##1 restart_o);
  leave_standby_c: cover property ($fell(standby_o));

endmodule
`default_nettype wire

// *** hdl/tsc_pkg.sv ***
package tsc_pkg;

  typedef logic [23:0] tsc_word_t;

  typedef enum logic [1:0]
  {
    TSC_SEQ_IDLE = 2'b00,
    TSC_SEQ_HOLD = 2'b01
  } tsc_seq_state_t;

  typedef struct packed
  {
    tsc_word_t pll_reg;
    tsc_word_t lat_reg;
    tsc_word_t amb_reg;
    tsc_word_t stby_reg;
    tsc_word_t init_reg;
    tsc_word_t mult_reg;
    logic ack;
    tsc_word_t rdata;
    logic restart;
  } tsc_regs_t;

  typedef struct packed
  {
    tsc_seq_state_t st;
    logic pll_seen;
    logic pll_apply;
    logic depth_start;
    logic pix_rst;
  } tsc_seq_t;

endpackage

// *** hdl/tsc_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsc_seq
  import tsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic quad_done_i,
  input wire logic frame_end_i,
  input wire logic readout_i,
  tsc_ctrl_if.seq ctl
);

  tsc_seq_t s;
  tsc_seq_t next_s;

  // sequencing of pll apply, depth start and pixel reset
  always_comb
  begin
    next_s = s;
    next_s.pll_apply = 1'b0;
    next_s.depth_start = 1'b0;
    // apply only on the high-then-low pulse from software [RQ1]
    if (ctl.pll_bit)
    begin
      next_s.pll_seen = 1'b1;
    end
    else if (s.pll_seen)
    begin
      next_s.pll_seen = 1'b0;
      next_s.pll_apply = 1'b1;
    end
    case (s.st)
      TSC_SEQ_IDLE:
      begin
        // standby blocks any new frame work [RQ5]
        if (quad_done_i && !ctl.standby)
        begin
          if (ctl.early_en)
          begin
            next_s.depth_start = 1'b1; // [RQ2]
          end
          else
          begin
            next_s.st = TSC_SEQ_HOLD; // [RQ2]
          end
        end
      end
      TSC_SEQ_HOLD:
      begin
        if (ctl.standby)
        begin
          next_s.st = TSC_SEQ_IDLE; // [RQ5]
        end
        else if (frame_end_i || ctl.early_en)
        begin
          next_s.depth_start = 1'b1;
          next_s.st = TSC_SEQ_IDLE;
        end
      end
      default:
      begin
        next_s.st = TSC_SEQ_IDLE;
      end
    endcase
    // pixel reset registered from readout: high from its second cycle to one cycle past its end [RQ3]
    next_s.pix_rst = ctl.amb_en && !ctl.standby && readout_i;
    // soft restart clears sequencer state too [RQ10]
    if (ctl.restart)
    begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign ctl.pll_apply = s.pll_apply;
  assign ctl.depth_start = s.depth_start;
  assign ctl.pix_rst = s.pix_rst;
  assign ctl.busy = (s.st == TSC_SEQ_HOLD);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  early_start_a: assert property ( // [RQ2]
    s.st == TSC_SEQ_IDLE && quad_done_i && ctl.early_en
    && !ctl.standby && !ctl.restart |=> s.depth_start)
    else $error("early depth start missing");
  late_wait_a: assert property ( // [RQ2]
    s.st == TSC_SEQ_IDLE && quad_done_i && !ctl.early_en
    && !ctl.standby && !ctl.restart
    |=> !s.depth_start && ctl.busy)
    else $error("depth start did not wait");
  pix_reset_a: assert property ( // [RQ3]
    ctl.amb_en && !ctl.standby && readout_i && !ctl.restart
    |=> s.pix_rst)
    else $error("pixel reset dropped in readout");
  pll_pulse_a: assert property ( // [RQ1]
    $fell(ctl.pll_bit) && !ctl.restart |=> s.pll_apply ##1 !s.pll_apply)
    else $error("pll apply pulse wrong");
  standby_quiet_a: assert property ( // [RQ5]
    ctl.standby |=> !s.depth_start)
    else $error("depth start during standby");

  early_path_c: cover property (quad_done_i && ctl.early_en ##1 s.depth_start);
  hold_path_c: cover property (ctl.busy ##[1:20] s.depth_start);
  pll_apply_c: cover property (s.pll_apply);

endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic quad_done = 1'b0;
  logic frame_end = 1'b0;
  logic readout = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, standby_o, init_done_o, pll_apply_o;
  logic depth_start_o, pix_rst_o, restart_o;
  logic [5:0] mod_m_o;
  logic [15:0] mod_frac_o;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [23:0] seed = 24'h000033;
  logic [31:0] q;
  // bench model: address, writable mask, reset value, expected contents
  logic [7:0] adr_t [6] = '{8'h08, 8'h10, 8'h14, 8'h20, 8'h2c, 8'h30};
  logic [23:0] msk_t [6] = '{24'h000004, 24'h400000, 24'h200000,
    24'h000004, 24'h002000, 24'h3fffff};
  logic [23:0] rst_t [6] = '{24'h0, 24'h0, 24'h0, 24'h000004, 24'h0,
    24'h100000};
  logic [23:0] model [6];

  // free-running 100 MHz clock
  always #5 clk_i = ~clk_i;

  tsc_ctrl_regs dut_u
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .quad_done_i(quad_done),
    .frame_end_i(frame_end), .readout_i(readout), .standby_o(standby_o),
    .init_done_o(init_done_o), .mod_m_o(mod_m_o), .mod_frac_o(mod_frac_o),
    .pll_apply_o(pll_apply_o), .depth_start_o(depth_start_o),
    .pix_rst_o(pix_rst_o), .restart_o(restart_o)
  );

  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // classic cycle; request held until ack is sampled, data taken there
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [23:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {8'h00, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
    begin
      error_cnt++;
      $display("mismatch at %0t: no ack", $time);
      print_verdict();
    end
  endtask

  // counts edges at which the chosen output is high
  task automatic cnt(input int s, input int n, input int exp);
    int c;
    logic b;
    c = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      case (s)
        0: b = pll_apply_o;
        1: b = depth_start_o;
        2: b = pix_rst_o;
        default: b = restart_o;
      endcase
      if (b === 1'b1)
        c++;
    end
    chk(32'(c), 32'(exp));
  endtask

  // one-cycle pulse on a sequencer input
  task automatic pulse(input int s);
    @(posedge clk_i);
    if (s == 0)
      quad_done <= 1'b1;
    else
      frame_end <= 1'b1;
    @(posedge clk_i);
    quad_done <= 1'b0;
    frame_end <= 1'b0;
  endtask

  task automatic read_all();
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b0, adr_t[i], 24'h0);
      chk(q, {8'h00, model[i]});
    end
  endtask

  function automatic logic [23:0] lfsr(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction

  // main sequence; reset held for 20 cycles
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    model = rst_t;
    read_all();
    chk({31'h0, standby_o}, 32'h1);
    chk({26'h0, mod_m_o}, 32'h10);
    // random data then all ones: reserved bits must drop
    for (int p = 0; p < 3; p++)
    begin
      for (int i = 0; i < 6; i++)
      begin
        seed = lfsr(seed);
        wb(1'b1, adr_t[i], (p == 2) ? 24'hffffff : seed);
        model[i] = ((p == 2) ? 24'hffffff : seed) & msk_t[i];
      end
      read_all();
      chk({10'h0, mod_m_o, mod_frac_o}, {8'h0, model[5]});
      chk({31'h0, init_done_o}, {31'h0, model[4][13]});
      chk({31'h0, standby_o}, {31'h0, model[3][2]});
    end
    wb(1'b0, 8'h3c, 24'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 4; i++)
      wb(1'b1, adr_t[i], 24'h0);
    // apply pulse only on the falling write
    wb(1'b1, 8'h08, 24'h000004);
    cnt(0, 6, 0);
    wb(1'b1, 8'h08, 24'h0);
    cnt(0, 6, 1);
    chk({31'h0, standby_o}, 32'h0);
    wb(1'b1, 8'h10, 24'h400000);
    pulse(0);
    cnt(1, 4, 1);
    wb(1'b1, 8'h10, 24'h0);
    pulse(0);
    cnt(1, 4, 0);
    pulse(1);
    cnt(1, 4, 1);
    // standby blocks processing even with early start on
    wb(1'b1, 8'h20, 24'h000004);
    wb(1'b1, 8'h10, 24'h400000);
    pulse(0);
    cnt(1, 4, 0);
    pulse(1);
    cnt(1, 4, 0);
    wb(1'b1, 8'h20, 24'h0);
    for (int e = 1; e >= 0; e--)
    begin
      wb(1'b1, 8'h14, e ? 24'h200000 : 24'h0); // shutter assumed on
      readout <= 1'b1;
      repeat (2) @(posedge clk_i);
      cnt(2, 5, e ? 5 : 0);
      readout <= 1'b0;
      repeat (2) @(posedge clk_i);
      cnt(2, 3, 0);
    end
    // soft restart returns every register to its default
    wb(1'b1, 8'h00, 24'h000001);
    // restart pulse stands in the ack cycle, so look at it there
    chk({31'h0, restart_o}, 32'h1);
    cnt(3, 4, 0);
    model = rst_t;
    read_all();
    chk({31'h0, standby_o}, 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
